// file: verilog/cspc_top.sv
// clock switch controller and 96 MHz pll control, axi4-lite registers
// assumes straps stable after reset and oscillator status synchronous to clock_i
`timescale 1ns/100ps
module cspc_top (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // axi4-lite write address and data
  input wire logic [3:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  // axi4-lite write response
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  // axi4-lite read
  input wire logic [3:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // configuration and oscillator status
  input wire cspc_pkg::cspc_cfg_t cfg_i,
  input wire cspc_pkg::cspc_osc_t osc_i,
  // clock tree control
  output logic [7:0] osc_on_o,
  output logic [2:0] sys_src_o,
  output logic [1:0] primary_submode_o,
  output logic pll_on_o,
  output logic [3:0] prescale_div_o,
  output logic [3:0] post_div_o,
  output logic [7:0] sys_mhz_o,
  output logic [7:0] usb_mhz_o
);
  ////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    cspc_pkg::cspc_unl_t hi_unl;
    cspc_pkg::cspc_unl_t lo_unl;
    logic [2:0] cur_src;
    logic [2:0] new_src;
    logic freeze;
    logic lock;
    logic cf;
    logic secondary_32khz_osc_en;
    logic sw_req;
    logic [1:0] system_postscaler;
    logic pll_runtime_enable;
    cspc_pkg::cspc_sw_t sw;
    logic [3:0] cnt;
    logic [7:0] osc_on;
  } cspc_st_t;

  cspc_st_t s_q;
  cspc_st_t s_d;

  // true when the selected source runs through the pll
  function automatic logic uses_pll(input logic [2:0] src);
    uses_pll = (src == cspc_pkg::CSPC_FRC_PLL) || (src == cspc_pkg::CSPC_PRI_PLL);
  endfunction

  // true when the source needs the crystal startup timer
  function automatic logic is_primary(input logic [2:0] src);
    is_primary = (src == cspc_pkg::CSPC_PRI) || (src == cspc_pkg::CSPC_PRI_PLL);
  endfunction

  logic sw_enabled;
  logic aw_fire;
  logic w_fire;
  logic do_write;
  logic do_read;
  logic wr_osc;
  logic hi_wr;
  logic lo_wr;
  logic [7:0] hi_b;
  logic [7:0] lo_b;
  logic [15:0] osc_rd;
  logic [15:0] div_rd;

  assign sw_enabled = ~cfg_i.switch_mode_config;
  assign awready_o = ~s_q.aw_got & ~s_q.bvalid;
  assign wready_o = ~s_q.w_got & ~s_q.bvalid;
  assign aw_fire = awvalid_i & awready_o;
  assign w_fire = wvalid_i & wready_o;
  assign do_write = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
  assign arready_o = ~s_q.rvalid;
  assign do_read = arvalid_i & arready_o;
  assign wr_osc = do_write && s_q.aw_addr[3:2] == cspc_pkg::OSC_CTRL_OFS[3:2];
  assign hi_wr = wr_osc & s_q.w_strb[1];
  assign lo_wr = wr_osc & s_q.w_strb[0];
  assign hi_b = s_q.w_data[15:8];
  assign lo_b = s_q.w_data[7:0];

  ////////////////////////////////////////////////////////////////
  // register read images
  always_comb begin
    osc_rd = 16'h0000;
    osc_rd[cspc_pkg::CURRENT_SOURCE_SEL_POS +: 3] = s_q.cur_src;
    osc_rd[cspc_pkg::NEW_SOURCE_SEL_POS +: 3] = s_q.new_src;
    osc_rd[cspc_pkg::FREEZE_POS] = s_q.freeze;
    osc_rd[cspc_pkg::LOCK_POS] = s_q.lock;
    osc_rd[cspc_pkg::CF_POS] = s_q.cf;
    osc_rd[cspc_pkg::SECONDARY_OSC_ENABLE_POS] = s_q.secondary_32khz_osc_en;
    osc_rd[cspc_pkg::SWREQ_POS] = s_q.sw_req;
    div_rd = 16'h0000;
    div_rd[cspc_pkg::SYSTEM_POSTSCALER_POS +: 2] = s_q.system_postscaler;
    div_rd[cspc_pkg::PLL_RUNTIME_ENABLE_POS] = s_q.pll_runtime_enable;
  end

  ////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    // bus channels
    if (aw_fire) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = awaddr_i;
    end
    if (w_fire) begin
      s_d.w_got = 1'b1;
      s_d.w_data = wdata_i;
      s_d.w_strb = wstrb_i;
    end
    if (do_write) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
    end
    if (s_q.bvalid && bready_i) begin
      s_d.bvalid = 1'b0;
    end
    if (do_read) begin
      s_d.rvalid = 1'b1;
      unique case (araddr_i[3:2])
        cspc_pkg::OSC_CTRL_OFS[3:2]: s_d.rdata = {16'h0000, osc_rd};
        cspc_pkg::CLK_DIV_OFS[3:2]: s_d.rdata = {16'h0000, div_rd};
        cspc_pkg::STATUS_OFS[3:2]: s_d.rdata = {24'h000000, 3'h0, s_q.sw, pll_on_o, sw_enabled};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    if (s_q.rvalid && rready_i) begin
      s_d.rvalid = 1'b0;
    end

    // upper byte unlock and write
    if (hi_wr) begin
      unique case (s_q.hi_unl)
        cspc_pkg::CSPC_OPEN: begin
          if (sw_enabled && !(s_q.freeze && s_q.sw == cspc_pkg::CSPC_IDLE && 1'b0)) begin
            s_d.new_src = hi_b[cspc_pkg::NEW_SOURCE_SEL_POS - 8 +: 3];
          end
          s_d.hi_unl = cspc_pkg::CSPC_ARM0;
        end
        cspc_pkg::CSPC_ARM1: s_d.hi_unl = (hi_b == cspc_pkg::HI_KEY2) ? cspc_pkg::CSPC_OPEN : cspc_pkg::CSPC_ARM0;
        default: s_d.hi_unl = (hi_b == cspc_pkg::HI_KEY1) ? cspc_pkg::CSPC_ARM1 : cspc_pkg::CSPC_ARM0;
      endcase
    end else if (do_write) begin
      s_d.hi_unl = cspc_pkg::CSPC_ARM0;
    end

    // lower byte unlock and write
    if (lo_wr) begin
      unique case (s_q.lo_unl)
        cspc_pkg::CSPC_OPEN: begin
          s_d.secondary_32khz_osc_en = lo_b[cspc_pkg::SECONDARY_OSC_ENABLE_POS];
          if (lo_b[cspc_pkg::FREEZE_POS]) begin
            s_d.freeze = 1'b1;
          end
          if (lo_b[cspc_pkg::CF_POS] == 1'b0) begin
            s_d.cf = 1'b0;
          end
          if (sw_enabled && lo_b[cspc_pkg::SWREQ_POS] && !s_q.freeze) begin
            s_d.sw_req = 1'b1;
          end
          s_d.lo_unl = cspc_pkg::CSPC_ARM0;
        end
        cspc_pkg::CSPC_ARM1: s_d.lo_unl = (lo_b == cspc_pkg::LO_KEY2) ? cspc_pkg::CSPC_OPEN : cspc_pkg::CSPC_ARM0;
        default: s_d.lo_unl = (lo_b == cspc_pkg::LO_KEY1) ? cspc_pkg::CSPC_ARM1 : cspc_pkg::CSPC_ARM0;
      endcase
    end else if (do_write) begin
      s_d.lo_unl = cspc_pkg::CSPC_ARM0;
    end

    // clock divider register has no unlock
    if (do_write && s_q.aw_addr[3:2] == cspc_pkg::CLK_DIV_OFS[3:2] && s_q.w_strb[0]) begin
      s_d.system_postscaler = s_q.w_data[cspc_pkg::SYSTEM_POSTSCALER_POS +: 2];
      s_d.pll_runtime_enable = s_q.w_data[cspc_pkg::PLL_RUNTIME_ENABLE_POS];
    end

    // clock monitor fail event; set wins over a software clear
    if (sw_enabled && osc_i.clock_fail) begin
      s_d.cf = 1'b1;
    end

    // switch sequencer
    unique case (s_q.sw)
      cspc_pkg::CSPC_IDLE: begin
        if (s_q.sw_req) begin
          s_d.sw = cspc_pkg::CSPC_CHECK;
        end
      end
      cspc_pkg::CSPC_CHECK: begin
        if (s_q.cur_src == s_q.new_src) begin
          s_d.sw_req = 1'b0;
          s_d.sw = cspc_pkg::CSPC_IDLE;
        end else begin
          s_d.lock = 1'b0;
          s_d.cf = osc_i.clock_fail & sw_enabled;
          s_d.osc_on[s_q.new_src] = 1'b1;
          s_d.sw = cspc_pkg::CSPC_START;
        end
      end
      cspc_pkg::CSPC_START: begin
        if (!is_primary(s_q.new_src) || osc_i.ost_done) begin
          s_d.sw = cspc_pkg::CSPC_PLLW;
        end
      end
      cspc_pkg::CSPC_PLLW: begin
        if (!uses_pll(s_q.new_src)) begin
          s_d.cnt = 4'h0;
          s_d.sw = cspc_pkg::CSPC_COUNT;
        end else if (osc_i.pll_lock && pll_on_o) begin
          s_d.lock = 1'b1;
          s_d.cnt = 4'h0;
          s_d.sw = cspc_pkg::CSPC_COUNT;
        end
      end
      cspc_pkg::CSPC_COUNT: begin
        if (osc_i.new_clk_tick) begin
          if (s_q.cnt == 4'(cspc_pkg::NEW_CLK_CYCLES - 1)) begin
            s_d.sw = cspc_pkg::CSPC_DONE;
          end else begin
            s_d.cnt = 4'(s_q.cnt + 4'h1);
          end
        end
      end
      cspc_pkg::CSPC_DONE: begin
        s_d.sw_req = 1'b0;
        s_d.cur_src = s_q.new_src;
        s_d.osc_on[s_q.cur_src] = 1'b0;
        s_d.sw = cspc_pkg::CSPC_IDLE;
      end
      default: s_d.sw = cspc_pkg::CSPC_IDLE;
    endcase

    // lock bit also drops whenever a non pll mode runs and the switch sequencer is idle
    if (!uses_pll(s_d.cur_src) && s_q.sw == cspc_pkg::CSPC_IDLE) begin
      s_d.lock = 1'b0;
    end else if (uses_pll(s_q.cur_src) && s_q.sw == cspc_pkg::CSPC_IDLE) begin
      s_d.lock = osc_i.pll_lock & pll_on_o;
    end

    // sources that must keep running
    s_d.osc_on[s_d.cur_src] = 1'b1;
    s_d.osc_on[cspc_pkg::CSPC_LOW_POWER_INTERNAL_RC] = s_d.osc_on[cspc_pkg::CSPC_LOW_POWER_INTERNAL_RC] | cfg_i.watchdog_on | sw_enabled;
    s_d.osc_on[cspc_pkg::CSPC_SEC] = s_d.osc_on[cspc_pkg::CSPC_SEC] | s_d.secondary_32khz_osc_en;

    // switching disabled: selection follows straps
    if (!sw_enabled) begin
      s_d.cur_src = cfg_i.initial_source_config;
      s_d.sw_req = 1'b0;
      s_d.freeze = 1'b0;
      s_d.sw = cspc_pkg::CSPC_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.system_postscaler <= cspc_pkg::SYSTEM_POSTSCALER_RST;
      s_q.hi_unl <= cspc_pkg::CSPC_ARM0;
      s_q.lo_unl <= cspc_pkg::CSPC_ARM0;
      s_q.sw <= cspc_pkg::CSPC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // clock tree outputs
  logic [3:0] post_div;
  always_comb begin
    unique case (s_q.system_postscaler)
      2'h0: post_div = 4'h1;
      2'h1: post_div = 4'h2;
      2'h2: post_div = 4'h4;
      default: post_div = 4'h8;
    endcase
  end

  always_comb begin
    unique case (cfg_i.pll_input_prescaler)
      3'h6: prescale_div_o = 4'h8;
      3'h7: prescale_div_o = 4'hC;
      default: prescale_div_o = 4'({1'b0, cfg_i.pll_input_prescaler} + 4'h1);
    endcase
  end

  assign bresp_o = 2'h0;
  assign rresp_o = 2'h0;
  assign bvalid_o = s_q.bvalid;
  assign rvalid_o = s_q.rvalid;
  assign rdata_o = s_q.rdata;
  assign osc_on_o = s_q.osc_on;
  assign sys_src_o = s_q.cur_src;
  assign primary_submode_o = cfg_i.primary_submode_config;
  assign pll_on_o = cfg_i.pll_enable_config | s_q.pll_runtime_enable;
  assign post_div_o = post_div;
  // 96 MHz / postscaler / 3 caps at 32 MHz
  assign sys_mhz_o = 8'((cspc_pkg::PLL_IN_MHZ * cspc_pkg::PLL_MULT) / cspc_pkg::SYS_FIXED_DIV) >> s_q.system_postscaler;
  assign usb_mhz_o = pll_on_o ? 8'(cspc_pkg::PLL_IN_MHZ * cspc_pkg::PLL_MULT / 2) : 8'h00;
endmodule

// file: verilog/cspc_pkg.sv
// package for the clock switch and pll control block
// assumes a 32-bit axi4-lite master and one 100 MHz clock
package cspc_pkg;
  // register byte addresses
  localparam logic [3:0] OSC_CTRL_OFS = 4'h0;
  localparam logic [3:0] CLK_DIV_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  // oscillator_control fields
  localparam int CURRENT_SOURCE_SEL_POS = 12;
  localparam int NEW_SOURCE_SEL_POS = 8;
  localparam int FREEZE_POS = 7;
  localparam int LOCK_POS = 5;
  localparam int CF_POS = 3;
  localparam int SECONDARY_OSC_ENABLE_POS = 1;
  localparam int SWREQ_POS = 0;
  // clock_divider_control fields
  localparam int SYSTEM_POSTSCALER_POS = 6;
  localparam int PLL_RUNTIME_ENABLE_POS = 5;
  // unlock keys
  localparam logic [7:0] HI_KEY1 = 8'h78;
  localparam logic [7:0] HI_KEY2 = 8'h9A;
  localparam logic [7:0] LO_KEY1 = 8'h46;
  localparam logic [7:0] LO_KEY2 = 8'h57;
  // reset values
  localparam logic [1:0] SYSTEM_POSTSCALER_RST = 2'h0;
  // timing
  localparam int NEW_CLK_CYCLES = 10;
  localparam int PLL_MULT = 24;
  localparam int SYS_FIXED_DIV = 3;
  localparam int PLL_IN_MHZ = 4;
  localparam int SYS_MAX_MHZ = 32;
  localparam int USB_MHZ = 48;
  localparam int CLK_MHZ = 100;
  // source encodings
  typedef enum logic [2:0] {
    CSPC_FRC = 3'h0, CSPC_FRC_PLL = 3'h1, CSPC_PRI = 3'h2, CSPC_PRI_PLL = 3'h3,
    CSPC_SEC = 3'h4, CSPC_LOW_POWER_INTERNAL_RC = 3'h5, CSPC_FRC16 = 3'h6, CSPC_FRC_DIV = 3'h7
  } cspc_src_t;
  typedef enum logic [1:0] {CSPC_ARM0, CSPC_ARM1, CSPC_OPEN} cspc_unl_t;
  typedef enum logic [2:0] {CSPC_IDLE, CSPC_CHECK, CSPC_START, CSPC_PLLW, CSPC_COUNT, CSPC_DONE} cspc_sw_t;
  // configuration straps
  typedef struct packed {
    logic switch_mode_config;
    logic [2:0] initial_source_config;
    logic [1:0] primary_submode_config;
    logic pll_enable_config;
    logic [2:0] pll_input_prescaler;
    logic watchdog_on;
  } cspc_cfg_t;
  // oscillator status signals
  typedef struct packed {
    logic ost_done;
    logic pll_lock;
    logic new_clk_tick;
    logic clock_fail;
  } cspc_osc_t;
endpackage

// file: verif/cspc_top_props.sv
// checker for cspc_top: bus handshakes and clock tree outputs
// assumes one clock domain and a bind onto every cspc_top instance
`timescale 1ns/100ps
module cspc_top_props (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // bus handshakes
  input wire logic awvalid_i,
  input wire logic awready_o,
  input wire logic wvalid_i,
  input wire logic wready_o,
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic rvalid_o,
  // straps and clock tree
  input wire cspc_pkg::cspc_cfg_t cfg_i,
  input wire logic [2:0] sys_src_o,
  input wire logic [1:0] primary_submode_o,
  input wire logic pll_on_o,
  input wire logic [3:0] prescale_div_o,
  input wire logic [3:0] post_div_o,
  input wire logic [7:0] sys_mhz_o,
  input wire logic [7:0] usb_mhz_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_ar_taken;
    arvalid_i && arready_o;
  endsequence
  sequence s_w_both;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  // codes 6 and 7 break the linear run of divisors
  function automatic logic [3:0] pre_div(input logic [2:0] c);
    case (c)
      3'h6: return 4'h8;
      3'h7: return 4'hC;
      default: return 4'(c) + 4'h1;
    endcase
  endfunction
  ////////////////////////////////////////
  a_read_answer: assert property (s_ar_taken |=> rvalid_o) else $error("read not answered");
  a_write_answer: assert property (s_w_both |-> ##[1:2] bvalid_o) else $error("write not answered");
  a_resp_hold: assert property (bvalid_o && !bready_i |=> bvalid_o) else $error("response dropped");
  a_ar_refused: assert property (rvalid_o |-> !arready_o) else $error("read taken while busy");
  a_strap_source: assert property (cfg_i.switch_mode_config |=>
    sys_src_o == $past(cfg_i.initial_source_config)) else $error("source not strap");
  a_submode_fixed: assert property (primary_submode_o == cfg_i.primary_submode_config)
    else $error("submode moved");
  a_pll_strap: assert property (cfg_i.pll_enable_config |-> pll_on_o) else $error("pll off");
  a_prescale_map: assert property (prescale_div_o == pre_div(cfg_i.pll_input_prescaler))
    else $error("prescaler wrong");
  a_post_rate: assert property (sys_mhz_o * post_div_o == 8'h20) else $error("system rate wrong");
  a_usb_rate: assert property (pll_on_o |-> usb_mhz_o == 8'h30) else $error("usb rate wrong");
  a_sys_ceiling: assert property (sys_mhz_o <= 8'h20) else $error("system rate too high");
endmodule
bind cspc_top cspc_top_props i_cspc_top_props (.clock_i, .nrst_i, .awvalid_i, .awready_o, .wvalid_i,
  .wready_o, .bvalid_o, .bready_i, .arvalid_i, .arready_o, .rvalid_o, .cfg_i, .sys_src_o, .primary_submode_o,
  .pll_on_o, .prescale_div_o, .post_div_o, .sys_mhz_o, .usb_mhz_o);

// file: verif/cspc_top_tb.sv
// bench for cspc_top: axi4-lite register tasks, strap and oscillator stimulus
// assumes the package is compiled first and the checker is bound
`timescale 1ns/100ps
module cspc_top_tb;
  localparam logic [3:0] OSC = cspc_pkg::OSC_CTRL_OFS;
  localparam logic [3:0] DIV = cspc_pkg::CLK_DIV_OFS;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] awaddr_i = 4'h0;
  logic [3:0] araddr_i = 4'h0;
  logic [3:0] wstrb_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic awvalid_i = 1'b0;
  logic wvalid_i = 1'b0;
  logic bready_i = 1'b0;
  logic arvalid_i = 1'b0;
  logic rready_i = 1'b0;
  cspc_pkg::cspc_cfg_t cfg_i = '0;
  cspc_pkg::cspc_osc_t osc_i = '0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, pll_on_o;
  logic [1:0] bresp_o, rresp_o, primary_submode_o;
  logic [31:0] rdata_o;
  logic [7:0] osc_on_o, sys_mhz_o, usb_mhz_o;
  logic [2:0] sys_src_o;
  logic [3:0] prescale_div_o, post_div_o;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int pre_tab [8] = '{1, 2, 3, 4, 5, 6, 8, 12};
  cspc_top i_cspc_top (.clock_i, .nrst_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i, .wvalid_i,
    .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o,
    .rvalid_o, .rready_i, .cfg_i, .osc_i, .osc_on_o, .sys_src_o, .primary_submode_o, .pll_on_o,
    .prescale_div_o, .post_div_o, .sys_mhz_o, .usb_mhz_o);
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // handshakes are judged at the falling edge, where nothing moves
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w, b;
    @(posedge clock_i);
    awaddr_i <= a;
    wdata_i <= d;
    wstrb_i <= s;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    forever begin
      @(negedge clock_i);
      aw = awvalid_i && awready_o;
      w = wvalid_i && wready_o;
      b = bvalid_o;
      if (b) check(bresp_o, 0, "bresp");
      @(posedge clock_i);
      if (aw) awvalid_i <= 1'b0;
      if (w) wvalid_i <= 1'b0;
      if (b) begin
        bready_i <= 1'b0;
        return;
      end
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
    logic t, r;
    @(posedge clock_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    forever begin
      @(negedge clock_i);
      t = arvalid_i && arready_o;
      r = rvalid_o;
      if (r) check(rdata_o & m, e, what);
      @(posedge clock_i);
      if (t) arvalid_i <= 1'b0;
      if (r) begin
        rready_i <= 1'b0;
        return;
      end
    end
  endtask
  task automatic set_new(input logic [2:0] n);
    wr(OSC, 32'h7800, 4'h2);
    wr(OSC, 32'h9A00, 4'h2);
    wr(OSC, {21'h0, n, 8'h0}, 4'h2);
  endtask
  task automatic set_low(input logic [7:0] v);
    wr(OSC, 32'h46, 4'h1);
    wr(OSC, 32'h57, 4'h1);
    wr(OSC, {24'h0, v}, 4'h1);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock_i);
      osc_i.new_clk_tick <= 1'b1;
      @(posedge clock_i);
      osc_i.new_clk_tick <= 1'b0;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic reset();
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
  endtask
  ////////////////////////////////////////
  initial begin
    cfg_i <= '{switch_mode_config: 1'b1, initial_source_config: 3'h2, primary_submode_config: 2'h2, default: '0};
    reset();
    rc(OSC, 32'h7000, 32'h2000, "strap source");
    set_new(3'h5);
    set_low(8'h01);
    cyc(5);
    rc(OSC, 32'h7001, 32'h2000, "disabled request");
    cyc(0);
    check(sys_src_o, 2, "disabled source");
    check(primary_submode_o, 2, "submode");
    cfg_i.switch_mode_config <= 1'b0;
    cfg_i.initial_source_config <= 3'h0;
    reset();
    wr(DIV, 32'h20, 4'h1);
    cyc(1);
    check(pll_on_o, 1, "runtime pll");
    check(usb_mhz_o, 48, "usb rate");
    set_low(8'h01);
    cyc(5);
    rc(OSC, 32'h7001, 32'h0, "redundant switch");
    wr(OSC, 32'h7800, 4'h2);
    wr(OSC, 32'h1100, 4'h2);
    wr(OSC, 32'h0300, 4'h2);
    wr(OSC, 32'h7800, 4'h2);
    wr(DIV, 32'h20, 4'h1);
    wr(OSC, 32'h9A00, 4'h2);
    wr(OSC, 32'h0300, 4'h2);
    rc(OSC, 32'h0700, 32'h0, "broken unlock");
    set_new(3'h3);
    rc(OSC, 32'h0700, 32'h0300, "new source");
    osc_i.clock_fail <= 1'b1;
    cyc(1);
    @(posedge clock_i);
    osc_i.clock_fail <= 1'b0;
    rc(OSC, 32'h8, 32'h8, "fail flag");
    // cf written as one so only the switch itself can clear it
    set_low(8'h09);
    cyc(3);
    rc(OSC, 32'h7029, 32'h1, "switch started");
    tick(12);
    cyc(1);
    check(sys_src_o, 0, "waits startup");
    @(posedge clock_i);
    osc_i.ost_done <= 1'b1;
    tick(12);
    cyc(1);
    check(sys_src_o, 0, "waits lock");
    @(posedge clock_i);
    osc_i.pll_lock <= 1'b1;
    cyc(4);
    tick(9);
    cyc(2);
    check(sys_src_o, 0, "nine ticks");
    tick(1);
    cyc(3);
    check(sys_src_o, 3, "ten ticks");
    rc(OSC, 32'h7021, 32'h3020, "switch done");
    cyc(0);
    check(osc_on_o[0], 0, "old source off");
    check(osc_on_o[5], 1, "low power rc kept");
    for (int i = 0; i < 4; i++) begin
      wr(DIV, {24'h0, 2'(i), 6'h20}, 4'h1);
      cyc(1);
      check(sys_mhz_o, 32 >> i, "system rate");
      check(post_div_o, 1 << i, "post divider");
      rc(DIV, 32'hE0, {24'h0, 2'(i), 6'h20}, "divider readback");
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_i);
      cfg_i.pll_input_prescaler <= 3'(i);
      cyc(1);
      check(prescale_div_o, 32'(pre_tab[i]), "prescaler");
    end
    wr(DIV, 32'h0, 4'h1);
    cyc(1);
    check(pll_on_o, 0, "pll off");
    @(posedge clock_i);
    cfg_i.pll_enable_config <= 1'b1;
    cyc(1);
    check(pll_on_o, 1, "strap pll");
    // freeze first, then a differing source: the request must be refused
    set_low(8'h80);
    set_new(3'h0);
    set_low(8'h81);
    cyc(3);
    rc(OSC, 32'h7081, 32'h3080, "frozen selection");
    rc(4'hC, 32'hFFFFFFFF, 32'h0, "unmapped read");
    give_verdict();
  end
endmodule
